// ==== src/sbtm_monitor.sv ====
// serial peripheral bus trigger monitor: framing, trigger and frame record
`timescale 1ns/1ps
`default_nettype none
// Behaviour
// - word length configurable, up to 32 bits
// - word assembled msb first or lsb first
// - gap duration used only without chip select
// - no chip select: frame starts after gap
// - words closer than gap share one frame
// - chip select active edge starts frame
// - chip select inactive edge ends frame
// - no chip select: gap after last edge ends
// - source setting picks mosi or miso data
// - trigger type: start, end, bit, pattern
// - offset bits skipped before pattern compare
// - first bit after frame start is one
// - bit trigger fires at bit offset+1
// - pattern length sets compared bit count
// - pattern trigger fires after last pattern bit
// - per bit mask excludes don't-care bits
// - set mask bits beyond length extend length
// - record frame start time versus trigger
// - record word count, words, frame state
// - slope setting selects sampling edge
// - per line polarity, cs low default
// - frame holds zero or more words
module sbtm_monitor #(
    parameter int WORD_MAX = sbtm_pkg::MAX_WORD
) (
    input  wire logic                          i_clk,
    input  wire logic                          i_nrst,
    input  wire logic                          i_sclk,
    input  wire logic                          i_cs,
    input  wire logic                          i_mosi,
    input  wire logic                          i_miso,
    input  wire logic                          i_use_cs,
    input  wire logic                          i_slope_fall,
    input  wire logic                          i_cs_low_active,
    input  wire logic                          i_mosi_low_active,
    input  wire logic                          i_miso_low_active,
    input  wire logic                          i_src_miso,
    input  wire logic [sbtm_pkg::WLEN_W-1:0]   i_word_len,
    input  wire logic                          i_lsb_first,
    input  wire logic [sbtm_pkg::GAP_W-1:0]    i_gap_cycles,
    input  wire logic [1:0]                    i_trig_type,
    input  wire logic [sbtm_pkg::BITCNT_W-1:0] i_bit_offset,
    input  wire logic [sbtm_pkg::PLEN_W-1:0]   i_pattern_length,
    input  wire logic [sbtm_pkg::PAT_MAX-1:0]  i_pat_value,
    input  wire logic [sbtm_pkg::PAT_MAX-1:0]  i_pat_care,
    output logic                               o_trigger,
    output logic                               o_in_frame,
    output logic [sbtm_pkg::PLEN_W-1:0]        o_eff_length,
    output logic                               o_word_valid,
    output logic [WORD_MAX-1:0]                o_word,
    output logic                               o_frame_done,
    output logic [sbtm_pkg::WCNT_W-1:0]        o_frame_words,
    output logic [sbtm_pkg::TIME_W-1:0]        o_frame_start,
    output logic                               o_start_valid,
    output logic [1:0]                         o_frame_state
);
    // ---------------------------------------------------------------
    // line synchronisers and polarity
    // ---------------------------------------------------------------
    logic [3:0] raw_s;
    sbtm_sync #(
        .WIDTH (4)
    ) u_sync (
        .i_clk   (i_clk),
        .i_nrst  (i_nrst),
        .i_async ({i_sclk, i_cs, i_mosi, i_miso}),
        .o_sync  (raw_s)
    );

    logic sclk_s;
    logic cs_act;
    logic data_bit;
    assign sclk_s   = raw_s[3];
    assign cs_act   = raw_s[2] ^ i_cs_low_active;
    assign data_bit = i_src_miso ? (raw_s[0] ^ i_miso_low_active) : (raw_s[1] ^ i_mosi_low_active);

    // ---------------------------------------------------------------
    // state
    // ---------------------------------------------------------------
    sbtm_pkg::sbtm_state_t             st_reg, st_next;
    logic                              sclk_d_reg, sclk_d_next;
    logic                              cs_d_reg, cs_d_next;
    logic [sbtm_pkg::GAP_W-1:0]        gap_reg, gap_next;
    logic [sbtm_pkg::BITCNT_W-1:0]     bit_reg, bit_next;
    logic [sbtm_pkg::WLEN_W-1:0]       wbit_reg, wbit_next;
    logic [WORD_MAX-1:0]               word_reg, word_next;
    logic [sbtm_pkg::PAT_MAX-1:0]      shf_reg, shf_next;
    logic [sbtm_pkg::TIME_W-1:0]       now_reg, now_next;
    logic [sbtm_pkg::WCNT_W-1:0]       wcnt_reg, wcnt_next;
    logic                              pat_pend_reg, pat_pend_next;
    logic                              trig_reg, trig_next;
    logic                              wv_reg, wv_next;
    logic [WORD_MAX-1:0]               wout_reg, wout_next;
    logic                              fd_reg, fd_next;
    logic [sbtm_pkg::WCNT_W-1:0]       fw_reg, fw_next;
    logic [sbtm_pkg::TIME_W-1:0]       fst_reg, fst_next;
    logic [sbtm_pkg::TIME_W-1:0]       fs_out_reg, fs_out_next;
    logic                              sv_reg, sv_next;
    logic [1:0]                        fstate_reg, fstate_next;
    logic [sbtm_pkg::PLEN_W-1:0]       elen_reg, elen_next;
    logic                              in_frame_reg, in_frame_next;

    // highest set bit of the care mask, plus one
    function automatic logic [sbtm_pkg::PLEN_W-1:0] care_span(input logic [sbtm_pkg::PAT_MAX-1:0] m);
        logic [sbtm_pkg::PLEN_W-1:0] n;
        n = '0;
        for (int k = 0; k < sbtm_pkg::PAT_MAX; k++) begin
            if (m[k]) begin
                n = sbtm_pkg::PLEN_W'(k + 1);
            end
        end
        return n;
    endfunction : care_span

    // masked compare of the newest len bits, oldest bit at the top
    function automatic logic pat_hit(input logic [sbtm_pkg::PAT_MAX-1:0] s,
                                     input logic [sbtm_pkg::PAT_MAX-1:0] v,
                                     input logic [sbtm_pkg::PAT_MAX-1:0] c,
                                     input logic [sbtm_pkg::PLEN_W-1:0]  len);
        logic ok;
        ok = 1'b1;
        for (int k = 0; k < sbtm_pkg::PAT_MAX; k++) begin
            if ((k < int'(len)) && c[k] && (s[k] != v[k])) begin
                ok = 1'b0;
            end
        end
        return ok;
    endfunction : pat_hit

    logic sclk_edge;
    logic cs_rise;
    logic cs_fall;
    logic gap_done;
    logic [sbtm_pkg::PLEN_W-1:0] span;
    logic [sbtm_pkg::PLEN_W-1:0] eff_len;
    logic [sbtm_pkg::WLEN_W-1:0] wlen;

    assign sclk_edge = i_slope_fall ? (sclk_d_reg & ~sclk_s) : (~sclk_d_reg & sclk_s);
    assign cs_rise   = cs_act & ~cs_d_reg;
    assign cs_fall   = ~cs_act & cs_d_reg;
    assign gap_done  = !i_use_cs && (gap_reg >= i_gap_cycles);
    // length grows to cover entered bits
    assign span      = care_span(i_pat_care);
    assign eff_len   = (span > i_pattern_length) ? span : i_pattern_length;
    // word length 1..32, zero taken as 32
    assign wlen      = (i_word_len == '0 || i_word_len > 6'(WORD_MAX)) ? 6'(WORD_MAX) : i_word_len;

    // ---------------------------------------------------------------
    // next state
    // ---------------------------------------------------------------
    always_comb begin
        logic                        fstart;
        logic                        fend;
        logic [sbtm_pkg::BITCNT_W-1:0] nb;
        fstart        = 1'b0;
        fend          = 1'b0;
        nb            = bit_reg;
        st_next       = st_reg;
        sclk_d_next   = sclk_s;
        cs_d_next     = cs_act;
        gap_next      = gap_reg;
        bit_next      = bit_reg;
        wbit_next     = wbit_reg;
        word_next     = word_reg;
        shf_next      = shf_reg;
        now_next      = now_reg + 32'h00000001;
        wcnt_next     = wcnt_reg;
        pat_pend_next = pat_pend_reg;
        trig_next     = 1'b0;
        wv_next       = 1'b0;
        wout_next     = wout_reg;
        fd_next       = 1'b0;
        fw_next       = fw_reg;
        fst_next      = fst_reg;
        fs_out_next   = fs_out_reg;
        sv_next       = 1'b0;
        fstate_next   = fstate_reg;
        elen_next     = eff_len;

        // gap timer: raw clock and selected data line both low, whatever the polarity
        if (sclk_edge || sclk_s || (i_src_miso ? raw_s[0] : raw_s[1])) begin
            gap_next = '0;
        end else if (gap_reg != '1) begin
            gap_next = gap_reg + 24'h000001;
        end

        case (st_reg)
            sbtm_pkg::SBTM_ST_IDLE: begin
                if (i_use_cs && cs_rise) begin
                    fstart = 1'b1;
                end else if (gap_done) begin
                    st_next = sbtm_pkg::SBTM_ST_GAP;
                end
            end
            sbtm_pkg::SBTM_ST_GAP: begin
                if (i_use_cs) begin
                    st_next = sbtm_pkg::SBTM_ST_IDLE;
                end else if (sclk_edge) begin
                    fstart = 1'b1;
                end
            end
            sbtm_pkg::SBTM_ST_FRAME: begin
                if (i_use_cs && cs_fall) begin
                    fend = 1'b1;
                end else if (gap_done) begin
                    fend = 1'b1;
                end
            end
            default: st_next = sbtm_pkg::SBTM_ST_IDLE;
        endcase

        if (fstart) begin
            st_next       = sbtm_pkg::SBTM_ST_FRAME;
            nb            = '0;
            bit_next      = '0;
            wbit_next     = '0;
            wcnt_next     = '0;
            word_next     = '0;
            shf_next      = '0;
            pat_pend_next = 1'b0;
            fst_next      = now_reg;
            if (i_trig_type == sbtm_pkg::SBTM_TRIG_START) begin
                trig_next = 1'b1;
            end
        end

        // the gap-mode start edge is also bit 1
        if ((st_next == sbtm_pkg::SBTM_ST_FRAME) && sclk_edge && !fend) begin
            nb       = (fstart ? '0 : bit_reg) + 16'h0001;
            bit_next = nb;
            if (i_trig_type == sbtm_pkg::SBTM_TRIG_BIT && nb == i_bit_offset + 16'h0001) begin
                trig_next = 1'b1;
            end
            // bit order, every word starts from zero
            if (i_lsb_first) begin
                word_next = ((wbit_reg == '0) ? '0 : word_reg) | (WORD_MAX'(data_bit) << wbit_reg);
            end else begin
                word_next = (wbit_reg == '0) ? WORD_MAX'(data_bit) : {word_reg[WORD_MAX-2:0], data_bit};
            end
            if (nb > i_bit_offset) begin
                shf_next = {shf_reg[sbtm_pkg::PAT_MAX-2:0], data_bit};
                if (nb == i_bit_offset + 16'(eff_len)) begin
                    pat_pend_next = 1'b1;
                end
            end
            if (wbit_reg + 6'h01 >= wlen) begin
                wbit_next = '0;
                wv_next   = 1'b1;
                wout_next = word_next;
                wcnt_next = wcnt_reg + 16'h0001;
            end else begin
                wbit_next = wbit_reg + 6'h01;
            end
        end

        if (pat_pend_reg) begin
            pat_pend_next = 1'b0;
            // trigger follows last pattern bit; recorded time is from frame start
            if (i_trig_type == sbtm_pkg::SBTM_TRIG_PATTERN &&
                pat_hit(shf_reg, i_pat_value, i_pat_care, elen_reg)) begin
                trig_next = 1'b1;
            end
        end

        if (fend) begin
            st_next     = sbtm_pkg::SBTM_ST_IDLE;
            fd_next     = 1'b1;
            fw_next     = wcnt_reg;
            // gap-mode start edge is also bit 1, so counts must be clean
            wbit_next   = '0;
            wcnt_next   = '0;
            fstate_next = (wcnt_reg == '0) ? 2'(sbtm_pkg::SBTM_FST_EMPTY) :
                          (wbit_reg != '0) ? 2'(sbtm_pkg::SBTM_FST_PARTIAL) : 2'(sbtm_pkg::SBTM_FST_OK);
            if (i_trig_type == sbtm_pkg::SBTM_TRIG_END) begin
                trig_next = 1'b1;
            end
        end

        if (trig_next) begin
            fs_out_next = now_reg - fst_next;
            sv_next     = 1'b1;
        end
        in_frame_next = (st_next == sbtm_pkg::SBTM_ST_FRAME);
    end

    // ---------------------------------------------------------------
    // registers
    // ---------------------------------------------------------------
    always_ff @(posedge i_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            st_reg       <= sbtm_pkg::SBTM_ST_IDLE;
            sclk_d_reg   <= 1'b0;
            // seen as active: a low-active select held at reset gives no false start
            cs_d_reg     <= 1'b1;
            gap_reg      <= sbtm_pkg::GAP_RST;
            bit_reg      <= sbtm_pkg::BITCNT_RST;
            wbit_reg     <= sbtm_pkg::WBIT_RST;
            word_reg     <= '0;
            shf_reg      <= '0;
            now_reg      <= sbtm_pkg::TIME_RST;
            wcnt_reg     <= sbtm_pkg::WCNT_RST;
            pat_pend_reg <= 1'b0;
            trig_reg     <= 1'b0;
            wv_reg       <= 1'b0;
            wout_reg     <= '0;
            fd_reg       <= 1'b0;
            fw_reg       <= sbtm_pkg::WCNT_RST;
            fst_reg      <= sbtm_pkg::TIME_RST;
            fs_out_reg   <= sbtm_pkg::TIME_RST;
            sv_reg       <= 1'b0;
            fstate_reg   <= 2'b00;
            elen_reg     <= '0;
            in_frame_reg <= 1'b0;
        end else begin
            st_reg       <= st_next;
            sclk_d_reg   <= sclk_d_next;
            cs_d_reg     <= cs_d_next;
            gap_reg      <= gap_next;
            bit_reg      <= bit_next;
            wbit_reg     <= wbit_next;
            word_reg     <= word_next;
            shf_reg      <= shf_next;
            now_reg      <= now_next;
            wcnt_reg     <= wcnt_next;
            pat_pend_reg <= pat_pend_next;
            trig_reg     <= trig_next;
            wv_reg       <= wv_next;
            wout_reg     <= wout_next;
            fd_reg       <= fd_next;
            fw_reg       <= fw_next;
            fst_reg      <= fst_next;
            fs_out_reg   <= fs_out_next;
            sv_reg       <= sv_next;
            fstate_reg   <= fstate_next;
            elen_reg     <= elen_next;
            in_frame_reg <= in_frame_next;
        end
    end

    assign o_trigger     = trig_reg;
    assign o_in_frame    = in_frame_reg;
    assign o_eff_length  = elen_reg;
    assign o_word_valid  = wv_reg;
    assign o_word        = wout_reg;
    assign o_frame_done  = fd_reg;
    assign o_frame_words = fw_reg;
    assign o_frame_start = fs_out_reg;
    assign o_start_valid = sv_reg;
    assign o_frame_state = fstate_reg;
endmodule : sbtm_monitor
`default_nettype wire

// ==== pkg/sbtm_pkg.sv ====
// shared constants and types for the serial bus trigger monitor
package sbtm_pkg;

    // ---------------------------------------------------------------
    // sizes
    // ---------------------------------------------------------------
    localparam int          MAX_WORD     = 32;
    localparam int          WLEN_W       = 6;
    localparam int          PAT_MAX      = 32;
    localparam int          PLEN_W       = 6;
    localparam int          BITCNT_W     = 16;
    localparam int          TIME_W       = 32;
    localparam int          WCNT_W       = 16;
    localparam int          GAP_W        = 24;
    localparam int          SYNC_STAGES  = 2;

    // ---------------------------------------------------------------
    // reset values
    // ---------------------------------------------------------------
    localparam logic [BITCNT_W-1:0] BITCNT_RST = 16'h0000;
    localparam logic [WLEN_W-1:0]   WBIT_RST   = 6'h00;
    localparam logic [GAP_W-1:0]    GAP_RST    = 24'h000000;
    localparam logic [TIME_W-1:0]   TIME_RST   = 32'h00000000;
    localparam logic [WCNT_W-1:0]   WCNT_RST   = 16'h0000;

    // ---------------------------------------------------------------
    // trigger kinds and frame states
    // ---------------------------------------------------------------
    typedef enum logic [1:0] {
        SBTM_TRIG_START   = 2'b00,
        SBTM_TRIG_END     = 2'b01,
        SBTM_TRIG_BIT     = 2'b10,
        SBTM_TRIG_PATTERN = 2'b11
    } sbtm_trig_t;

    typedef enum logic [1:0] {
        SBTM_FST_OK      = 2'b00,
        SBTM_FST_PARTIAL = 2'b01,
        SBTM_FST_EMPTY   = 2'b10
    } sbtm_fstate_t;

    typedef enum logic [1:0] {
        SBTM_ST_IDLE  = 2'b00,
        SBTM_ST_FRAME = 2'b01,
        SBTM_ST_GAP   = 2'b10
    } sbtm_state_t;

endpackage : sbtm_pkg

// ==== src/sbtm_sync.sv ====
// two stage synchroniser for the monitored bus lines
`timescale 1ns/1ps
`default_nettype none
module sbtm_sync #(
    parameter int WIDTH = 4
) (
    input  wire logic             i_clk,
    input  wire logic             i_nrst,
    input  wire logic [WIDTH-1:0] i_async,
    output logic      [WIDTH-1:0] o_sync
);
    logic [WIDTH-1:0] meta_reg;
    logic [WIDTH-1:0] sync_reg;

    // first stage is read only by the second stage
    always_ff @(posedge i_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            meta_reg <= '0;
            sync_reg <= '0;
        end else begin
            meta_reg <= i_async;
            sync_reg <= meta_reg;
        end
    end

    assign o_sync = sync_reg;
endmodule : sbtm_sync
`default_nettype wire

// ==== dv/sbtm_monitor_props.sv ====
// assertion checker watching the ports of the bus trigger monitor
`timescale 1ns/1ps
`default_nettype none
module sbtm_monitor_props (
    input wire logic                          i_clk,
    input wire logic                          i_nrst,
    input wire logic                          i_cs,
    input wire logic                          i_use_cs,
    input wire logic                          i_cs_low_active,
    input wire logic [1:0]                    i_trig_type,
    input wire logic [sbtm_pkg::PLEN_W-1:0]   i_pattern_length,
    input wire logic [sbtm_pkg::PAT_MAX-1:0]  i_pat_care,
    input wire logic                          o_trigger,
    input wire logic                          o_in_frame,
    input wire logic [sbtm_pkg::PLEN_W-1:0]   o_eff_length,
    input wire logic                          o_word_valid,
    input wire logic                          o_frame_done,
    input wire logic                          o_start_valid
);
    // ---------------------------------------------------------------
    // helper logic
    // ---------------------------------------------------------------
    logic                        cs_act;
    logic [sbtm_pkg::PLEN_W-1:0] exp_len;
    assign cs_act = i_cs ^ i_cs_low_active;
    always_comb begin
        exp_len = i_pattern_length;
        for (int k = 0; k < 32; k++) begin
            if (i_pat_care[k] && k + 1 > int'(exp_len)) begin
                exp_len = 6'(k + 1);
            end
        end
    end
    default clocking cb @(posedge i_clk);
    endclocking
    default disable iff (!i_nrst);
    // ---------------------------------------------------------------
    // sequences and properties
    // ---------------------------------------------------------------
    sequence s_cs_on;
        i_use_cs && $rose(cs_act);
    endsequence
    sequence s_cs_off;
        i_use_cs && $fell(cs_act) && o_in_frame;
    endsequence
    a_cs_frame_start: assert property (s_cs_on |-> ##[1:6] o_in_frame)
        else $error("frame not entered after select went active");
    a_cs_frame_end: assert property (s_cs_off |-> ##[1:6] o_frame_done)
        else $error("frame not closed after select went inactive");
    a_done_leaves_frame: assert property (o_frame_done |-> !o_in_frame)
        else $error("frame still open at frame completion");
    a_trig_one_pulse: assert property (o_trigger |=> !o_trigger)
        else $error("trigger longer than one cycle");
    a_start_with_trig: assert property (o_trigger || o_start_valid |-> o_trigger && o_start_valid)
        else $error("start time not reported with trigger");
    a_done_one_pulse: assert property (o_frame_done |=> !o_frame_done)
        else $error("frame completion longer than one cycle");
    a_word_spacing: assert property (o_word_valid |=> !o_word_valid [*4])
        else $error("words closer than one bit time");
    a_word_in_frame: assert property (o_word_valid |-> o_in_frame)
        else $error("word outside a frame");
    a_eff_length: assert property ($stable(i_pattern_length) && $stable(i_pat_care)
        |=> o_eff_length == $past(exp_len))
        else $error("effective pattern length wrong");
    a_trig_in_frame: assert property (o_trigger && i_trig_type != 2'h1 |-> o_in_frame)
        else $error("trigger outside a frame");
endmodule : sbtm_monitor_props
`default_nettype wire

// ==== dv/sbtm_far_end.sv ====
// far side model: master and slave driving the monitored lines
`timescale 1ns/1ps
`default_nettype none
module sbtm_far_end (
    output logic o_sclk,
    output logic o_cs,
    output logic o_mosi,
    output logic o_miso
);
    int   bit_no = 0;
    logic cs_on  = 1'b0;
    initial begin
        o_sclk = 1'b0;
        o_cs   = 1'b1;
        o_mosi = 1'b0;
        o_miso = 1'b0;
    end
    task set_idle(input logic csl);
        o_cs   = csl;
        cs_on  = ~csl;
        o_mosi = 1'b0;
        o_miso = 1'b0;
    endtask : set_idle
    task send(input logic [63:0] mo, input logic [63:0] mi, input int n, input int wl, input logic ucs,
              input logic sf);
        bit_no = 0;
        if (ucs) o_cs = cs_on;
        #40;
        for (int i = 0; i < n; i++) begin
            o_mosi = mo[i];
            o_miso = mi[i];
            #12;
            o_sclk = 1'b1;
            if (!sf) bit_no++;
            #24;
            o_sclk = 1'b0;
            if (sf) bit_no++;
            #12;
            if ((i + 1) % wl == 0) #80;
        end
        #40;
        // released data lines invert with select, go low without it
        if (ucs) o_cs = ~cs_on;
        o_mosi = ucs ? ~o_mosi : 1'b0;
        o_miso = ucs ? ~o_miso : 1'b0;
    endtask : send
endmodule : sbtm_far_end
`default_nettype wire

// ==== dv/sbtm_monitor_tb_top.sv ====
// self-checking bench for the bus trigger monitor
`timescale 1ns/1ps
`default_nettype none
module sbtm_monitor_tb_top;
    logic i_clk = 1'b0, i_nrst = 1'b0, i_sclk, i_cs, i_mosi, i_miso;
    logic i_use_cs = 1'b1, i_slope_fall = 1'b0, i_cs_low_active = 1'b1, i_lsb_first = 1'b0;
    logic i_mosi_low_active = 1'b0, i_miso_low_active = 1'b0, i_src_miso = 1'b0;
    logic [5:0]  i_word_len = 6'h08, i_pattern_length = 6'h01, o_eff_length;
    logic [23:0] i_gap_cycles = 24'h000005;
    logic [1:0]  i_trig_type = 2'h0, o_frame_state;
    logic [15:0] i_bit_offset = 16'h0000, o_frame_words, got_words;
    logic [31:0] i_pat_value = 32'h00000000, i_pat_care = 32'h00000001, o_word, o_frame_start;
    logic        o_trigger, o_in_frame, o_word_valid, o_frame_done, o_start_valid;
    logic [1:0]  got_state;
    logic [31:0] got_fs;
    logic [31:0] wq[$];
    int          n_errors = 0, check_count = 0, n_trig = 0, n_done = 0, trig_bit = 0;
    int          wl, n, len, of;

    sbtm_monitor i_dut (.i_clk, .i_nrst, .i_sclk, .i_cs, .i_mosi, .i_miso, .i_use_cs, .i_slope_fall,
        .i_cs_low_active, .i_mosi_low_active, .i_miso_low_active, .i_src_miso, .i_word_len, .i_lsb_first,
        .i_gap_cycles, .i_trig_type, .i_bit_offset, .i_pattern_length, .i_pat_value, .i_pat_care, .o_trigger,
        .o_in_frame, .o_eff_length, .o_word_valid, .o_word, .o_frame_done, .o_frame_words, .o_frame_start,
        .o_start_valid, .o_frame_state);
    sbtm_far_end i_far (.o_sclk(i_sclk), .o_cs(i_cs), .o_mosi(i_mosi), .o_miso(i_miso));

    initial forever #2 i_clk = ~i_clk;

    always @(negedge i_clk) begin
        if (o_trigger === 1'b1) begin
            n_trig++;
            got_fs = o_frame_start;
            trig_bit = i_far.bit_no;
        end
        if (o_word_valid === 1'b1) wq.push_back(o_word);
        if (o_frame_done === 1'b1) begin
            n_done++;
            got_words = o_frame_words;
            got_state = o_frame_state;
        end
    end
    // ---------------------------------------------------------------
    // tasks
    // ---------------------------------------------------------------
    task chk(input logic [31:0] got, input logic [31:0] exp);
        check_count++;
        if (got !== exp) begin
            n_errors++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk
    task print_verdict;
        $display("errors %0d of %0d checks", n_errors, check_count);
        if (n_errors == 0 && check_count > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask : print_verdict
    function automatic int exp_bit(input int tt, input logic ucs, input int o, input int l, input int nb);
        case (tt)
            0: return ucs ? 0 : 1;
            1: return nb;
            2: return o + 1;
            default: return o + l;
        endcase
    endfunction : exp_bit
    task run(input logic ucs, sf, csl, src, pl, ls, input int w, tt, o, l, nb, input logic bad);
        logic [63:0] d, mo, mi;
        logic [31:0] e;
        int          i, b;
        d  = {$urandom, $urandom};
        mo = {$urandom, $urandom};
        mi = {$urandom, $urandom};
        if (src) mi = d ^ {64{pl}};
        else mo = d ^ {64{pl}};
        @(negedge i_clk);
        i_far.set_idle(csl);
        {i_use_cs, i_slope_fall, i_cs_low_active, i_src_miso, i_lsb_first} = {ucs, sf, csl, src, ls};
        i_mosi_low_active = src ? 1'b0 : pl;
        i_miso_low_active = src ? pl : 1'b0;
        i_word_len = 6'(w);
        i_trig_type = 2'(tt);
        i_bit_offset = 16'(o);
        i_pattern_length = 6'(l);
        i_gap_cycles = ucs ? 24'h000005 : 24'h000028;
        i_pat_care = ($urandom & (32'hFFFFFFFF >> (32 - l))) | (32'h1 << (l - 1));
        if (l > 8) i_pat_care[7:4] = 4'h0;
        i_pat_value = $urandom;
        for (i = 0; i < l; i++) begin
            if (i_pat_care[l-1-i]) i_pat_value[l-1-i] = d[o+i] ^ (bad && i == 0);
        end
        repeat (60) @(negedge i_clk);
        n_trig = 0;
        n_done = 0;
        trig_bit = -1;
        got_fs = 32'hFFFFFFFF;
        wq.delete();
        i_far.send(mo, mi, nb, w, ucs, sf);
        for (i = 0; i < 300 && n_done == 0; i++) @(negedge i_clk);
        if (n_done == 0) begin
            n_errors++;
            print_verdict();
        end
        repeat (4) @(negedge i_clk);
        chk(n_trig, bad ? 0 : 1);
        if (!bad) chk(trig_bit, exp_bit(tt, ucs, o, l, nb));
        chk(got_words, nb / w);
        chk(got_state, (nb % w) != 0 ? 1 : 0);
        chk(wq.size(), nb / w);
        if (tt == 0 && !bad) chk(got_fs, 0);
        chk(o_in_frame, 0);
        for (i = 0; i < nb / w && i < wq.size(); i++) begin
            e = 32'h00000000;
            for (b = 0; b < w; b++) begin
                if (ls) e[b] = d[i*w+b];
                else e = {e[30:0], d[i*w+b]};
            end
            chk(wq[i], e);
        end
    endtask : run
    // ---------------------------------------------------------------
    // main sequence
    // ---------------------------------------------------------------
    initial begin
        void'($urandom(59990));
        repeat (12) @(negedge i_clk);
        i_nrst = 1'b1;
        run(1, 0, 1, 0, 0, 0, 8, 0, 0, 1, 16, 0);
        run(1, 0, 1, 1, 1, 1, 8, 1, 0, 1, 20, 0);
        run(1, 1, 1, 0, 0, 0, 32, 2, 4, 1, 40, 0);
        run(1, 0, 0, 0, 0, 0, 5, 3, 3, 9, 15, 0);
        run(1, 0, 1, 0, 0, 0, 5, 3, 3, 9, 15, 1);
        run(0, 0, 1, 0, 0, 0, 8, 1, 0, 1, 24, 0);
        run(0, 1, 1, 0, 0, 1, 6, 3, 7, 12, 30, 0);
        run(1, 0, 1, 0, 0, 0, 1, 2, 0, 1, 3, 0);
        repeat (6) begin
            wl = 1 + $urandom % 32;
            n = wl + $urandom % (65 - wl);
            len = 1 + $urandom % (n < 32 ? n : 32);
            of = $urandom % (n - len + 1);
            run($urandom, $urandom, $urandom, $urandom, $urandom, $urandom, wl, $urandom % 4, of, len, n, 0);
        end
        @(negedge i_clk);
        i_pattern_length = 6'h03;
        i_pat_care = 32'h00000040;
        repeat (3) @(negedge i_clk);
        chk(o_eff_length, 7);
        print_verdict();
    end
endmodule : sbtm_monitor_tb_top

bind sbtm_monitor sbtm_monitor_props i_props (.i_clk, .i_nrst, .i_cs, .i_use_cs, .i_cs_low_active, .i_trig_type,
    .i_pattern_length, .i_pat_care, .o_trigger, .o_in_frame, .o_eff_length, .o_word_valid, .o_frame_done,
    .o_start_valid);
`default_nettype wire
